// >>> rtl/irp_pkg.sv
// package: constants for the two-wire register readback port
package irp_pkg;
  localparam logic [4:0]  DEV_ADDR_HI    = 5'h13;   // 10011
  localparam logic [6:0]  IDX_RESET      = 7'h00;
  localparam logic [6:0]  IDX_MAX        = 7'h7f;
  localparam logic [6:0]  IDX_WRAP       = 7'h00;
  localparam logic [6:0]  UNDEF_LO       = 7'h10;
  localparam logic [6:0]  UNDEF_HI       = 7'h1f;
  localparam logic [7:0]  UNDEF_DATA     = 8'h00;
  localparam int          SYS_CLK_HZ     = 20000000;
  localparam int          SPIKE_NS       = 50;
  localparam int          SPIKE_WIN_NS   = 600;
  // filter length: cycles covering the widest suppressed spike, plus one, at least one
  localparam int          FILT_CYC_RAW   = (SPIKE_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000 + 1;
  localparam int          FILT_CYC       = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
  localparam logic [3:0]  FILT_CNT_MAX   = 4'(FILT_CYC);
  localparam logic [3:0]  FILT_CNT_RST   = 4'h0;
  localparam logic [3:0]  BIT_CNT_RST    = 4'h0;
  localparam logic [3:0]  BIT_CNT_BYTE   = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WRX  = 3'b011,
    ST_WACK = 3'b100,
    ST_RTX  = 3'b101,
    ST_RACK = 3'b110
  } irp_state_t;
endpackage

// >>> rtl/irp_sync.sv
// two-flop synchroniser for one bus line
module irp_sync
  import irp_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic srst_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// >>> rtl/irp_filt.sv
// glitch filter: output follows input only after it holds steady
module irp_filt
  import irp_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic srst_in,
  input  wire logic line_in,
  output logic      line_out
);
  logic       out_q;
  logic       out_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  always_comb
  begin
    out_d = out_q;
    cnt_d = FILT_CNT_RST;
    if (line_in != out_q)
    begin
      cnt_d = cnt_q + 4'h1;
      if (cnt_q + 4'h1 >= FILT_CNT_MAX)
      begin
        out_d = line_in;
        cnt_d = FILT_CNT_RST;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      out_q <= 1'b1;
      cnt_q <= FILT_CNT_RST;
    end
    else
    begin
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end

  assign line_out = out_q;
endmodule

// >>> rtl/irp_port.sv
// two-wire slave: index register, register write and readback
module irp_port
  import irp_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       addr_select_hi_in,
  input  wire logic       addr_select_lo_in,
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic       reg_defined_in,
  output logic [6:0]      reg_index_out,
  output logic [7:0]      reg_wdata_out,
  output logic            reg_wr_out
);
  logic       scl_s;
  logic       sda_s;
  logic       scl_f;
  logic       sda_f;
  logic       asel_hi_s;
  logic       asel_lo_s;
  irp_state_t st_q;
  irp_state_t st_d;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [6:0] idx_q;
  logic [6:0] idx_d;
  logic       idx_phase_q;
  logic       idx_phase_d;
  logic       rd_q;
  logic       rd_d;
  logic       oe_q;
  logic       oe_d;
  logic       nack_q;
  logic       nack_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic       wr_q;
  logic       wr_d;
  logic       start_det;
  logic       stop_det;
  logic       scl_rise;
  logic       scl_fall;
  logic       scl_d;
  logic       sda_d;
  logic [6:0] own_addr;
  logic [7:0] rd_byte_w;

  function automatic logic [6:0] idx_inc(input logic [6:0] v);
    idx_inc = (v == IDX_MAX) ? IDX_WRAP : v + 7'h01;
  endfunction

  function automatic logic [7:0] rd_byte(input logic [6:0] v, input logic [7:0] d,
                                         input logic def);
    if (!def && v >= UNDEF_LO && v <= UNDEF_HI)
      rd_byte = UNDEF_DATA;
    else
      rd_byte = d;
  endfunction

  // line and strap synchronisers, then glitch filters
  irp_sync u_sync_scl (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .async_in(scl_in),
                       .sync_out(scl_s));
  irp_sync u_sync_sda (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .async_in(sda_in),
                       .sync_out(sda_s));
  irp_sync u_sync_ahi (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
                       .async_in(addr_select_hi_in), .sync_out(asel_hi_s));
  irp_sync u_sync_alo (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
                       .async_in(addr_select_lo_in), .sync_out(asel_lo_s));
  // spikes up to the suppressed width never reach the protocol logic
  irp_filt u_filt_scl (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .line_in(scl_s),
                       .line_out(scl_f));
  irp_filt u_filt_sda (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .line_in(sda_s),
                       .line_out(sda_f));

  // edge and condition detection on filtered lines
  assign scl_rise  = scl_f & ~scl_q;
  assign scl_fall  = ~scl_f & scl_q;
  assign start_det = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_det  = scl_f & scl_q & ~sda_q & sda_f;
  assign own_addr  = {DEV_ADDR_HI, asel_hi_s, asel_lo_s};
  // byte the read path puts on the line for the current index
  assign rd_byte_w = rd_byte(idx_q, reg_rdata_in, reg_defined_in);

  always_comb
  begin
    st_d        = st_q;
    sh_d        = sh_q;
    bit_d       = bit_q;
    idx_d       = idx_q;
    idx_phase_d = idx_phase_q;
    rd_d        = rd_q;
    oe_d        = oe_q;
    nack_d      = nack_q;
    wdata_d     = wdata_q;
    wr_d        = 1'b0;
    scl_d       = scl_f;
    sda_d       = sda_f;
    if (start_det)
    begin
      st_d  = ST_ADDR;
      bit_d = BIT_CNT_RST;
      oe_d  = 1'b0;
    end
    else if (stop_det)
    begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          oe_d = 1'b0;
        end
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            sh_d  = {sh_q[6:0], sda_f};
            bit_d = bit_q + 4'h1;
          end
          else if (scl_fall && bit_q == BIT_CNT_BYTE)
          begin
            if (sh_q[7:1] == own_addr)
            begin
              st_d        = ST_AACK;
              oe_d        = 1'b1;
              rd_d        = sh_q[0];
              idx_phase_d = ~sh_q[0];
            end
            else
              st_d = ST_IDLE;
          end
        end
        ST_AACK:
        begin
          if (scl_fall)
          begin
            bit_d = BIT_CNT_RST;
            if (rd_q)
            begin
              // index stays put for the first byte after a write
              st_d = ST_RTX;
              sh_d = rd_byte_w;
              oe_d = ~rd_byte_w[7];
            end
            else
            begin
              st_d = ST_WRX;
              oe_d = 1'b0;
            end
          end
        end
        ST_WRX:
        begin
          if (scl_rise)
          begin
            sh_d  = {sh_q[6:0], sda_f};
            bit_d = bit_q + 4'h1;
          end
          else if (scl_fall && bit_q == BIT_CNT_BYTE)
          begin
            st_d = ST_WACK;
            oe_d = 1'b1;
            if (idx_phase_q)
            begin
              // bit 7 of the index byte is ignored
              idx_d = sh_q[6:0];
            end
            else
            begin
              wdata_d = sh_q;
              wr_d    = 1'b1;
            end
          end
        end
        ST_WACK:
        begin
          if (scl_fall)
          begin
            // ack slot over: index byte ends the index phase, a data byte steps the index
            bit_d = BIT_CNT_RST;
            st_d  = ST_WRX;
            oe_d  = 1'b0;
            if (idx_phase_q)
              idx_phase_d = 1'b0;
            else
              idx_d = idx_inc(idx_q);
          end
        end
        ST_RTX:
        begin
          if (scl_fall)
          begin
            bit_d = bit_q + 4'h1;
            if (bit_q == BIT_CNT_BYTE - 4'h1)
            begin
              st_d  = ST_RACK;
              oe_d  = 1'b0;
              idx_d = idx_inc(idx_q);
            end
            else
            begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
            nack_d = sda_f; // master NACK ends the read
          else if (scl_fall)
          begin
            bit_d = BIT_CNT_RST;
            if (nack_q)
            begin
              st_d = ST_IDLE;
              oe_d = 1'b0;
            end
            else
            begin
              st_d = ST_RTX;
              sh_d = rd_byte_w;
              oe_d = ~rd_byte_w[7];
            end
          end
        end
        default:
        begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      st_q        <= ST_IDLE;
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      sh_q        <= 8'h00;
      bit_q       <= BIT_CNT_RST;
      idx_q       <= IDX_RESET;
      idx_phase_q <= 1'b0;
      rd_q        <= 1'b0;
      oe_q        <= 1'b0;
      nack_q      <= 1'b0;
      wdata_q     <= 8'h00;
      wr_q        <= 1'b0;
    end
    else
    begin
      st_q        <= st_d;
      scl_q       <= scl_d;
      sda_q       <= sda_d;
      sh_q        <= sh_d;
      bit_q       <= bit_d;
      idx_q       <= idx_d;
      idx_phase_q <= idx_phase_d;
      rd_q        <= rd_d;
      oe_q        <= oe_d;
      nack_q      <= nack_d;
      wdata_q     <= wdata_d;
      wr_q        <= wr_d;
    end
  end

  assign sda_out       = 1'b0;
  assign sda_oe_out    = oe_q;
  assign reg_index_out = idx_q;
  assign reg_wdata_out = wdata_q;
  assign reg_wr_out    = wr_q;
endmodule

// >>> verif/irp_chk.sv
// checker: assertions on the readback port pins
module irp_chk
  import irp_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       srst_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic [6:0] reg_index_out,
  input wire logic       reg_wr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);
  logic [6:0] nxt_q;
  logic [6:0] nxt_d;
  always_comb
  begin
    nxt_d = reg_wr_out ? reg_index_out + 7'h01 : nxt_q;
  end
  always_ff @(posedge sys_clk_in)
  begin
    nxt_q <= nxt_d;
  end
  sequence stop_s;
    scl_in && $rose(sda_in);
  endsequence
  sequence wr_s;
    reg_wr_out ##1 !reg_wr_out;
  endsequence
  AST_RST_VAL: assert property (
    $fell(srst_in) |-> !sda_oe_out && !reg_wr_out && reg_index_out == IDX_RESET)
    else $error("reset values wrong");
  AST_ODRAIN: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  AST_WR_GAP: assert property (wr_s |-> !reg_wr_out[*7])
    else $error("write pulses too close");
  AST_WR_LOW: assert property (reg_wr_out |-> !scl_in)
    else $error("write outside ack slot");
  AST_WR_ACK: assert property (reg_wr_out |-> ##[0:4] sda_oe_out)
    else $error("written byte not acked");
  AST_IDX_INC: assert property (
    reg_wr_out |-> ##[2:30] reg_index_out == nxt_q)
    else $error("index not advanced after write");
  AST_STOP_IDLE: assert property (stop_s |-> ##4 !sda_oe_out[*4])
    else $error("sda driven after stop");
  AST_SYNC: assert property (
    $rose(sda_oe_out) |-> !$past(scl_in) && !$past(scl_in, 2))
    else $error("drive before synchronised fall");
endmodule

// >>> verif/irp_master.sv
// bus master model: drives scl and pulls sda low
module irp_master
(
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic spike;
  initial
  begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
    spike = 1'b0;
  end
  // one bit: low 300 ns, high 100 ns, sampled late in high
  task automatic bit_cyc(input logic pull, output logic smp);
    #50 sda_pull_out = pull;
    if (spike)
    begin
      #100 scl_out = 1'b1; // single 50 ns spike
      #50 scl_out = 1'b0;
      #100 spike = 1'b0;
    end
    else
    begin
      #250;
    end
    scl_out = 1'b1;
    #90 smp = sda_in;
    #10 scl_out = 1'b0;
  endtask
  // start and repeated start, same address follows
  task automatic start;
    #50 sda_pull_out = 1'b0;
    #250 scl_out = 1'b1;
    #300 sda_pull_out = 1'b1;
    #300 scl_out = 1'b0;
  endtask
  task automatic stop;
    #50 sda_pull_out = 1'b1;
    #250 scl_out = 1'b1;
    #300 sda_pull_out = 1'b0;
    #600;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cyc(!b[i], s);
    end
    bit_cyc(1'b0, s);
    ack = !s;
  endtask
  // ack every byte but the last
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cyc(1'b0, d[i]);
    end
    bit_cyc(!last, s);
  endtask
endmodule

// >>> verif/testbench.sv
// testbench: readback port against the bus master model
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("mismatch %0t got %h exp %h", $time, g, e); \
    end \
  end
module testbench
  import irp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk;
  logic       srst;
  logic       scl;
  logic       pull;
  logic       sda_w;
  logic       sda_o;
  logic       oe;
  logic       wr;
  logic       ack;
  logic       defd;
  logic [1:0] sel;
  logic [6:0] idx;
  logic [7:0] wdata;
  logic [7:0] d;
  logic [7:0] mem [128];
  int         error_cnt;
  int         checked;
  // rows: select pins, address, expected ack
  logic [9:0] rows [8] = '{10'h099, 10'h19b, 10'h29d, 10'h39f,
                           10'h39c, 10'h018, 10'h0b8, 10'h298};
  assign sda_w = !pull && (!oe || sda_o);
  assign defd = !(idx >= UNDEF_LO && idx <= UNDEF_HI);
  always @(posedge clk)
  begin
    if (wr)
    begin
      mem[idx] <= wdata;
    end
  end
  irp_port irp_port_i (.sys_clk_in(clk), .srst_in(srst), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(oe), .addr_select_hi_in(sel[1]),
    .addr_select_lo_in(sel[0]), .reg_rdata_in(mem[idx]), .reg_defined_in(defd),
    .reg_index_out(idx), .reg_wdata_out(wdata), .reg_wr_out(wr));
  irp_master bm_i (.sda_in(sda_w), .scl_out(scl), .sda_pull_out(pull));
  task automatic end_sim;
    if (error_cnt == 0 && checked > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // index load by a write phase
  task automatic setidx(input logic [6:0] i);
    bm_i.start();
    bm_i.wbyte(8'h9c, ack);
    bm_i.wbyte({1'b0, i}, ack);
  endtask
  // address with read bit after the restart
  task automatic rd_open;
    bm_i.start();
    bm_i.wbyte(8'h9d, ack);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #400000;
    error_cnt++;
    end_sim();
  end
  initial
  begin
    srst = 1'b1;
    sel = 2'b10;
    for (int i = 0; i < 128; i++)
    begin
      mem[i] = 8'(i) ^ 8'h25;
    end
    repeat (6) @(negedge clk);
    `CHK(idx, IDX_RESET)
    `CHK(oe, 1'b0)
    srst = 1'b0;
    repeat (10) @(negedge clk);
    foreach (rows[r])
    begin
      sel = rows[r][9:8];
      @(negedge clk);
      bm_i.start();
      bm_i.wbyte({rows[r][7:1], 1'b0}, ack);
      bm_i.stop();
      `CHK(ack, rows[r][0])
    end
    setidx(7'h7e);
    bm_i.spike = 1'b1;
    bm_i.wbyte(8'ha5, ack);
    bm_i.wbyte(8'h3c, ack);
    bm_i.stop();
    `CHK(mem[7'h7e], 8'ha5)
    `CHK(mem[7'h7f], 8'h3c)
    `CHK(idx, IDX_WRAP)
    setidx(7'h7f);
    rd_open();
    bm_i.rbyte(1'b0, d);
    `CHK(d, 8'h3c)
    bm_i.rbyte(1'b1, d);
    `CHK(d, 8'h25)
    bm_i.stop();
    setidx(UNDEF_HI);
    rd_open();
    bm_i.rbyte(1'b0, d);
    `CHK(d, UNDEF_DATA)
    bm_i.rbyte(1'b1, d);
    `CHK(d, 8'h05)
    bm_i.stop();
    `CHK(idx, 7'h21)
    setidx(7'h40);
    rd_open();
    repeat (8) @(negedge clk);
    `CHK(oe, 1'b1)
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    `CHK(oe, 1'b0)
    `CHK(idx, IDX_RESET)
    bm_i.stop();
    repeat (10) @(negedge clk);
    rd_open();
    bm_i.rbyte(1'b1, d);
    `CHK(d, 8'h25)
    bm_i.stop();
    end_sim();
  end
endmodule
bind irp_port irp_chk irp_chk_i (.sys_clk_in, .srst_in, .scl_in, .sda_in, .sda_out,
  .sda_oe_out, .reg_index_out, .reg_wr_out);
